// file: hw/esi_fifo.sv
// parameterised fifo with registered read data
`timescale 1ns/1ps
module esi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk, // clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic inValid, // write request
  output logic inReady, // room available
  input wire logic [WIDTH-1:0] inData, // write data
  output logic outValid, // read data valid
  input wire logic outReady, // consumer takes data
  output logic [WIDTH-1:0] outData // registered read data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [AW:0] count_r, count_nxt;
  logic [WIDTH-1:0] outData_r, outData_nxt;
  logic outValid_r, outValid_nxt;
  logic doWr, doRd;

  // pointer, count and output stage update
  always_comb
  begin
    inReady = (count_r != DEPTH[AW:0]);
    doWr = inValid && inReady;
    doRd = (count_r != '0) && (!outValid_r || outReady);
    wrPtr_nxt = doWr ? wrPtr_r + 1'b1 : wrPtr_r;
    rdPtr_nxt = doRd ? rdPtr_r + 1'b1 : rdPtr_r;
    count_nxt = count_r + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
    outData_nxt = doRd ? mem_r[rdPtr_r] : outData_r;
    outValid_nxt = doRd ? 1'b1 : (outReady ? 1'b0 : outValid_r);
  end

  // registers only
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      outData_r <= '0;
      outValid_r <= 1'b0;
    end
    else if (ce)
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
      outData_r <= outData_nxt;
      outValid_r <= outValid_nxt;
      if (doWr)
        mem_r[wrPtr_r] <= inData;
    end
  end

  assign outValid = outValid_r;
  assign outData = outData_r;
endmodule // esi_fifo

// file: hw/esi_pkg.sv
// constants for the spare bit insertion control block
// Behaviour
// - control bit 6 set: non-align frame Si bits come from the non-align Si pattern
// - control bit 5 set: remote alarm bits come from the remote alarm pattern
// - control bit 3 set: Sa5 positions come from the Sa5 pattern
// - control bit 2 set: Sa6 positions come from the Sa6 pattern
// - control bit 1 set: Sa7 positions come from the Sa7 pattern
// - control bit 0 set: Sa8 positions come from the Sa8 pattern
// - patterns sampled once per multiframe as the multiframe flag sets; 2 ms to update
// - pattern MSB is transmitted first, then descending across eight occurrences
// - eight pattern registers at consecutive addresses: align Si, non-align Si, alarm, Sa4..Sa8
package esi_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h1c;
  localparam logic [7:0] STAT_OFS = 8'h1d;
  localparam logic [7:0] PAT_BASE = 8'h50;
  localparam logic [7:0] PAT_LAST = 8'h57;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PAT_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam int STAT_MF_BIT = 5;
  localparam int STAT_WIN_BIT = 4;
  localparam int SI_BIT = 7;
  localparam int ALARM_BIT = 5;
  localparam int PAT_ALIGN_SI = 0;
  localparam int PAT_NONALIGN_SI = 1;
  localparam int NUM_PAT = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W = 8;
  localparam int UPDATE_WINDOW_MS = 2;
  localparam int CLK_KHZ = 125000;
  localparam int UPDATE_CYCLES = UPDATE_WINDOW_MS * CLK_KHZ;
  localparam int WIN_W = 18;
endpackage

// file: hw/esi_spare_insert.sv
// transmit Si/Sa/remote alarm insertion with host registers and output fifo
`timescale 1ns/1ps
module esi_spare_insert #(
  parameter int UPDATE_CYCLES = esi_pkg::UPDATE_CYCLES
) (
  input wire logic sys_clk, // 125 MHz clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [7:0] hostAddr, // host port address
  input wire logic [7:0] hostWrData, // host port write data
  input wire logic hostWr, // host write strobe
  input wire logic hostRd, // host read strobe
  output logic [7:0] hostRdData, // host read data, registered
  input wire logic fmtValid, // timeslot 0 byte from formatter valid
  output logic fmtReady, // block accepts the byte
  input wire logic [7:0] fmtByte, // timeslot 0 byte as formatted
  input wire logic [3:0] fmtFrameNum, // frame number in crc4 multiframe
  output logic lineValid, // outgoing byte valid
  input wire logic lineReady, // line side takes byte
  output logic [7:0] lineByte, // outgoing timeslot 0 byte
  output logic mfFlag // multiframe flag, sticky
);
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] pat_r [esi_pkg::NUM_PAT];
  logic [7:0] pat_nxt [esi_pkg::NUM_PAT];
  logic [7:0] shadow_r [esi_pkg::NUM_PAT];
  logic [7:0] shadow_nxt [esi_pkg::NUM_PAT];
  logic mfFlag_r, mfFlag_nxt;
  logic [esi_pkg::WIN_W-1:0] winCnt_r, winCnt_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic fifoInReady, accept, mfStart, alignFrame;
  logic [2:0] occ;
  logic [7:0] outByte;

  // pattern index for a register address
  function automatic logic [2:0] patIdx(input logic [7:0] addr);
    logic [7:0] d;
    d = addr - esi_pkg::PAT_BASE;
    return d[2:0];
  endfunction

  function automatic logic isPat(input logic [7:0] addr);
    return (addr >= esi_pkg::PAT_BASE) && (addr <= esi_pkg::PAT_LAST);
  endfunction

  // bit of a pattern for occurrence k, msb first
  function automatic logic patBit(input logic [7:0] pat, input logic [2:0] k);
    return pat[3'd7 - k];
  endfunction

  assign accept = fmtValid && fifoInReady && ce;
  assign fmtReady = fifoInReady && ce;
  assign mfStart = accept && (fmtFrameNum == 4'h0);
  assign alignFrame = !fmtFrameNum[0];
  assign occ = fmtFrameNum[3:1];

  // host register file: control and the eight patterns
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    for (int i = 0; i < esi_pkg::NUM_PAT; i++)
      pat_nxt[i] = pat_r[i];
    if (hostWr && hostAddr == esi_pkg::CTRL_OFS)
      ctrl_nxt = hostWrData;
    if (hostWr && isPat(hostAddr))
      pat_nxt[patIdx(hostAddr)] = hostWrData;
  end

  // read mux, unmapped addresses read zero
  always_comb
  begin
    rdData_nxt = rdData_r;
    if (hostRd)
    begin
      if (hostAddr == esi_pkg::CTRL_OFS)
        rdData_nxt = ctrl_r;
      else if (hostAddr == esi_pkg::STAT_OFS)
      begin
        rdData_nxt = esi_pkg::STAT_RST;
        rdData_nxt[esi_pkg::STAT_MF_BIT] = mfFlag_r;
        rdData_nxt[esi_pkg::STAT_WIN_BIT] = (winCnt_r != '0);
      end
      else if (isPat(hostAddr))
        rdData_nxt = pat_r[patIdx(hostAddr)];
      else
        rdData_nxt = 8'h00;
    end
  end

  // multiframe sampling, flag and update window
  always_comb
  begin
    for (int i = 0; i < esi_pkg::NUM_PAT; i++)
      shadow_nxt[i] = mfStart ? pat_r[i] : shadow_r[i];
    mfFlag_nxt = mfFlag_r;
    if (hostWr && hostAddr == esi_pkg::STAT_OFS && hostWrData[esi_pkg::STAT_MF_BIT])
      mfFlag_nxt = 1'b0;
    if (mfStart)
      mfFlag_nxt = 1'b1; // set wins over clear
    if (mfStart)
      winCnt_nxt = UPDATE_CYCLES[esi_pkg::WIN_W-1:0];
    else if (winCnt_r != '0)
      winCnt_nxt = winCnt_r - 1'b1;
    else
      winCnt_nxt = winCnt_r;
  end

  // overhead bit insertion; frame 0 uses the freshly sampled patterns
  always_comb
  begin
    logic [7:0] src [esi_pkg::NUM_PAT];
    for (int i = 0; i < esi_pkg::NUM_PAT; i++)
      src[i] = (fmtFrameNum == 4'h0) ? pat_r[i] : shadow_r[i];
    outByte = fmtByte;
    if (alignFrame)
    begin
      if (ctrl_r[7 - esi_pkg::PAT_ALIGN_SI])
        outByte[esi_pkg::SI_BIT] = patBit(src[esi_pkg::PAT_ALIGN_SI], occ);
    end
    else
    begin
      if (ctrl_r[7 - esi_pkg::PAT_NONALIGN_SI])
        outByte[esi_pkg::SI_BIT] = patBit(src[esi_pkg::PAT_NONALIGN_SI], occ);
      // alarm and Sa4..Sa8: byte bit b maps to pattern 7-b and control bit b
      for (int b = 0; b <= esi_pkg::ALARM_BIT; b++)
        if (ctrl_r[b])
          outByte[b] = patBit(src[7 - b], occ);
    end
  end

  // register stage
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      ctrl_r <= esi_pkg::CTRL_RST;
      for (int i = 0; i < esi_pkg::NUM_PAT; i++)
      begin
        pat_r[i] <= esi_pkg::PAT_RST;
        shadow_r[i] <= esi_pkg::PAT_RST;
      end
      mfFlag_r <= 1'b0;
      winCnt_r <= '0;
      rdData_r <= 8'h00;
    end
    else if (ce)
    begin
      ctrl_r <= ctrl_nxt;
      for (int i = 0; i < esi_pkg::NUM_PAT; i++)
      begin
        pat_r[i] <= pat_nxt[i];
        shadow_r[i] <= shadow_nxt[i];
      end
      mfFlag_r <= mfFlag_nxt;
      winCnt_r <= winCnt_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign hostRdData = rdData_r;
  assign mfFlag = mfFlag_r;

  // outgoing buffer; a stalled line stalls the formatter
  esi_fifo #(
    .WIDTH(esi_pkg::DATA_W),
    .DEPTH(esi_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .inValid(fmtValid),
    .inReady(fifoInReady),
    .inData(outByte),
    .outValid(lineValid),
    .outReady(lineReady),
    .outData(lineByte)
  );

  // checks
  AST_SHADOW_SAMPLE: assert property (@(posedge sys_clk) disable iff (!resetn)
    mfStart |=> shadow_r[3] == $past(pat_r[3]) && shadow_r[7] == $past(pat_r[7]))
    else $error("patterns not sampled at multiframe start");
  AST_SHADOW_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
    !mfStart |=> $stable(shadow_r[0]) && $stable(shadow_r[2]))
    else $error("patterns resampled outside multiframe start");
  AST_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
    mfStart |=> mfFlag_r && winCnt_r == UPDATE_CYCLES[esi_pkg::WIN_W-1:0])
    else $error("multiframe flag or window not started");
  AST_ALIGN_SI: assert property (@(posedge sys_clk) disable iff (!resetn)
    accept && alignFrame && fmtFrameNum != 4'h0 |->
      outByte[7] == (ctrl_r[7] ? shadow_r[0][7 - occ] : fmtByte[7]))
    else $error("align frame Si wrong");
  AST_NONALIGN_SI: assert property (@(posedge sys_clk) disable iff (!resetn)
    accept && !alignFrame |-> outByte[7] == (ctrl_r[6] ? shadow_r[1][7 - occ] : fmtByte[7]))
    else $error("non-align Si wrong");
  AST_ALARM: assert property (@(posedge sys_clk) disable iff (!resetn)
    accept && !alignFrame |-> outByte[5] == (ctrl_r[5] ? shadow_r[2][7 - occ] : fmtByte[5]))
    else $error("remote alarm bit wrong");
  AST_SA5: assert property (@(posedge sys_clk) disable iff (!resetn)
    accept && !alignFrame |-> outByte[3] == (ctrl_r[3] ? shadow_r[4][7 - occ] : fmtByte[3]))
    else $error("Sa5 bit wrong");
  AST_SA6: assert property (@(posedge sys_clk) disable iff (!resetn)
    accept && !alignFrame |-> outByte[2] == (ctrl_r[2] ? shadow_r[5][7 - occ] : fmtByte[2]))
    else $error("Sa6 bit wrong");
  AST_SA7: assert property (@(posedge sys_clk) disable iff (!resetn)
    accept && !alignFrame |-> outByte[1] == (ctrl_r[1] ? shadow_r[6][7 - occ] : fmtByte[1]))
    else $error("Sa7 bit wrong");
  AST_SA8: assert property (@(posedge sys_clk) disable iff (!resetn)
    accept && !alignFrame |-> outByte[0] == (ctrl_r[0] ? shadow_r[7][7 - occ] : fmtByte[0]))
    else $error("Sa8 bit wrong");
  AST_SA4: assert property (@(posedge sys_clk) disable iff (!resetn)
    accept && !alignFrame |-> outByte[4] == (ctrl_r[4] ? shadow_r[3][7 - occ] : fmtByte[4]))
    else $error("Sa4 bit wrong");
  AST_PAT_READ: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && hostRd && hostAddr == 8'h52 |=> hostRdData == $past(pat_r[2]))
    else $error("remote alarm pattern not at its address");
  // a write of one to the flag clears it unless a multiframe starts in that cycle
  AST_FLAG_CLEAR: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && hostWr && hostAddr == esi_pkg::STAT_OFS && hostWrData[esi_pkg::STAT_MF_BIT] && !mfStart |=> !mfFlag_r)
    else $error("multiframe flag not cleared by host write");
  // the update window counts down one step per enabled cycle
  AST_WIN_COUNT: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && !mfStart && winCnt_r != '0 |=> winCnt_r == $past(winCnt_r) - 1'b1)
    else $error("update window counter not counting down");
endmodule // esi_spare_insert

// file: sim/e1_spare_bit_insert_control_tb.sv
// self-checking bench for the spare bit insertion block
`timescale 1ns/1ps
module e1_spare_bit_insert_control_tb;
  logic sys_clk = 1'b0, resetn = 1'b0, ce = 1'b1, hostWr = 1'b0, hostRd = 1'b0, fmtValid = 1'b0, stall = 1'b0;
  logic [7:0] hostAddr = 8'h00, hostWrData = 8'h00, fmtByte = 8'h00, hostRdData, lineByte, c, b;
  logic [3:0] fmtFrameNum = 4'h0;
  logic fmtReady, lineValid, lineReady, mfFlag;
  logic [7:0] pat [8];
  logic [7:0] expq [$];
  int nFail = 0, numChecks = 0, seen = 0;
  // clock at 125 MHz
  initial forever #4 sys_clk = ~sys_clk;
  esi_spare_insert #(.UPDATE_CYCLES(20)) i_dut (.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostWr(hostWr), .hostRd(hostRd),
    .hostRdData(hostRdData), .fmtValid(fmtValid), .fmtReady(fmtReady), .fmtByte(fmtByte),
    .fmtFrameNum(fmtFrameNum), .lineValid(lineValid), .lineReady(lineReady),
    .lineByte(lineByte), .mfFlag(mfFlag));
  esi_line_sink i_sink (.sys_clk(sys_clk), .stall(stall), .lineValid(lineValid),
    .lineByte(lineByte), .lineReady(lineReady));
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      nFail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hwrite(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    hostAddr = a;
    hostWrData = d;
    hostWr = 1'b1;
    @(negedge sys_clk);
    hostWr = 1'b0;
  endtask
  task automatic rcheck(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    hostAddr = a;
    hostRd = 1'b1;
    @(negedge sys_clk);
    hostRd = 1'b0;
    check(hostRdData, e);
  endtask
  // expected timeslot 0 byte: enabled bits from the pattern, msb first
  function automatic logic [7:0] expb(input logic [7:0] cc, input logic [7:0] bb, input logic [3:0] f);
    logic [7:0] r;
    int k;
    r = bb;
    k = 7 - int'(f[3:1]);
    if (!f[0])
    begin
      if (cc[7]) r[7] = pat[0][k];
    end
    else
    begin
      if (cc[6]) r[7] = pat[1][k];
      if (cc[5]) r[5] = pat[2][k];
      for (int j = 0; j < 5; j++)
        if (cc[4-j]) r[4-j] = pat[3+j][k];
    end
    return r;
  endfunction
  // offer one byte and hold it until the block takes it
  task automatic send(input logic [3:0] f, input logic [7:0] d, input logic [7:0] e);
    int t;
    t = 0;
    @(negedge sys_clk);
    fmtFrameNum = f;
    fmtByte = d;
    fmtValid = 1'b1;
    while (fmtReady !== 1'b1 && t < 200)
    begin
      @(negedge sys_clk);
      t++;
    end
    if (t == 200) nFail++;
    @(negedge sys_clk);
    fmtValid = 1'b0;
    expq.push_back(e);
  endtask
  // wait for the line side to collect all queued bytes, then compare
  task automatic drain;
    int t;
    t = 0;
    while (i_sink.cnt < seen + expq.size() && t < 300)
    begin
      @(negedge sys_clk);
      t++;
    end
    if (t == 300) nFail++;
    foreach (expq[i]) check(i_sink.got[seen + i], expq[i]);
    // every offered byte has been taken, so nothing stays valid
    check({7'h00, lineValid}, 8'h00);
    seen += expq.size();
    expq.delete();
  endtask
  // watchdog
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    nFail++;
    $display("watchdog expired at %0t", $time);
    giveVerdict();
  end
  // test sequence
  initial
  begin
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    rcheck(esi_pkg::CTRL_OFS, esi_pkg::CTRL_RST);
    rcheck(esi_pkg::STAT_OFS, esi_pkg::STAT_RST);
    for (int i = 0; i < 8; i++) rcheck(esi_pkg::PAT_BASE + 8'(i), esi_pkg::PAT_RST);
    for (int i = 0; i < 8; i++) hwrite(esi_pkg::PAT_BASE + 8'(i), 8'h11 * 8'(i + 1));
    for (int i = 0; i < 8; i++) rcheck(esi_pkg::PAT_BASE + 8'(i), 8'h11 * 8'(i + 1));
    rcheck(8'h30, 8'h00);
    @(negedge sys_clk);
    ce = 1'b0;
    hwrite(esi_pkg::CTRL_OFS, 8'hff);
    ce = 1'b1;
    rcheck(esi_pkg::CTRL_OFS, 8'h00);
    hwrite(esi_pkg::CTRL_OFS, 8'hc3);
    rcheck(esi_pkg::CTRL_OFS, 8'hc3);
    $display("test registers done");
    for (int m = 0; m < 10; m++)
    begin
      c = (m == 0) ? 8'h00 : (m == 9) ? 8'hff : 8'h01 << (m - 1);
      for (int i = 0; i < 8; i++)
      begin
        pat[i] = 8'ha5 + 8'(m * 19 + i * 41);
        hwrite(esi_pkg::PAT_BASE + 8'(i), pat[i]);
      end
      hwrite(esi_pkg::CTRL_OFS, c);
      hwrite(esi_pkg::STAT_OFS, 8'h20);
      check({7'h00, mfFlag}, 8'h00);
      for (int f = 0; f < 16; f++)
      begin
        b = 8'h3c ^ {4'(f), 4'(f)};
        send(4'(f), b, expb(c, b, 4'(f)));
        if (f == 0) check({7'h00, mfFlag}, 8'h01);
        // flag set and update window still open just after the multiframe start
        if (f == 0) rcheck(esi_pkg::STAT_OFS, 8'h30);
        // late update must not show in the rest of this multiframe
        if (f == 3) for (int i = 0; i < 8; i++) hwrite(esi_pkg::PAT_BASE + 8'(i), ~pat[i]);
      end
      drain();
      // window closed by now, flag still sticky
      rcheck(esi_pkg::STAT_OFS, 8'h20);
      $display("test multiframe %0d control %h done", m, c);
    end
    hwrite(esi_pkg::CTRL_OFS, 8'h00);
    stall = 1'b1;
    for (int i = 0; i < 17; i++) send(4'(i), 8'(i * 7), 8'(i * 7));
    @(negedge sys_clk);
    check({7'h00, fmtReady}, 8'h00);
    stall = 1'b0;
    drain();
    check({7'h00, fmtReady}, 8'h01);
    $display("test buffer fill done");
    giveVerdict();
  end
endmodule // e1_spare_bit_insert_control_tb

// file: sim/esi_line_sink.sv
// line side consumer model that can stall the outgoing byte stream
`timescale 1ns/1ps
module esi_line_sink (
  input wire logic sys_clk, // clock
  input wire logic stall, // hold the stream off while high
  input wire logic lineValid, // byte offered by the block
  input wire logic [7:0] lineByte, // offered byte
  output logic lineReady = 1'b0 // consumer takes byte
);
  logic [7:0] got [256];
  int cnt = 0;
  // ready changes just after an edge so the block sees a settled level
  always @(posedge sys_clk) lineReady <= !stall;
  // record every byte handed over
  always @(posedge sys_clk)
  begin
    if (lineValid === 1'b1 && lineReady === 1'b1)
    begin
      got[cnt[7:0]] <= lineByte;
      cnt <= cnt + 1;
    end
  end
endmodule // esi_line_sink
